// file: hdl/spcr_pkg.sv
// constants, field layout and carrier types of the serial port config registers
// assumes one core clock; the serial engine decodes frames and presents byte accesses
//
// Contract
// - bit 7 picks separate read-output pin; clear keeps it high impedance.
// - bit 6 set means LSB first, address increments; clear MSB first, decrements.
// - in I2C mode bits 7 and 6 are unused and ignored.
// - writing bit 5 soft resets; self-clears; reloads storage or defaults by pin.
// - read-only variant code register at address 0x003.
// - bit 0 of 0x004 selects buffer or active bank for reads.
// - sixteen bit user version tag at 0x005/0x006, default zero, storage only.
// - bit 4 of config has no function and reads zero.
package spcr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_PORT_CFG = 12'h000;
  localparam logic [11:0] ADDR_VARIANT  = 12'h003;
  localparam logic [11:0] ADDR_BANK_SEL = 12'h004;
  localparam logic [11:0] ADDR_TAG_LOW  = 12'h005;
  localparam logic [11:0] ADDR_TAG_HIGH = 12'h006;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_SEPARATE_BIT  = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_SOFT_RST_BIT  = 5;
  localparam int CFG_UNUSED_BIT    = 4;
  localparam int BANK_SEL_BIT      = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic       RST_SEPARATE  = 1'b0;
  localparam logic       RST_LSB_FIRST = 1'b0;
  localparam logic       RST_BANK_SEL  = 1'b0;
  localparam logic [7:0] RST_TAG_LOW   = 8'h00;
  localparam logic [7:0] RST_TAG_HIGH  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        separate_out;
    logic        lsb_first;
    logic        bank_sel;
    logic [15:0] tag;
  } spcr_image_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } spcr_wr_t;

  localparam spcr_image_t RST_IMAGE = '{
    separate_out: RST_SEPARATE,
    lsb_first:    RST_LSB_FIRST,
    bank_sel:     RST_BANK_SEL,
    tag:          {RST_TAG_HIGH, RST_TAG_LOW}
  };

endpackage

// file: hdl/spcr_regs.sv
// serial port configuration and identification register bank
// assumes the serial engine gives one byte write or read address per cycle,
// on the core clock; mode and load-select pins arrive asynchronously
module spcr_regs
  import spcr_pkg::*;
#(
  parameter logic [7:0] VARIANT_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire spcr_wr_t          i_wr,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  input  wire logic              i_update,
  input  wire logic              i_i2c_mode,
  input  wire logic              i_load_select,
  input  wire spcr_image_t       i_nv_image,
  output logic [7:0]             o_rd_data,
  output logic                   o_separate_output_enable,
  output logic                   o_lsb_first,
  output logic                   o_soft_reset,
  output logic                   o_nv_load,
  output logic [15:0]            o_user_version_tag
);

  // ------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ------------------------------------------------------------
  logic [1:0] sync_s1;
  logic [1:0] sync_s2;
  logic [1:0] sync_s3;
  logic [1:0] sync_q;
  wire  [1:0] sync_agree  = sync_s2 ~^ sync_s3;
  wire  [1:0] next_sync_q = (sync_agree & sync_s3) | (~sync_agree & sync_q);
  wire        i2c_q       = sync_q[1];
  wire        load_q      = sync_q[0];

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sync_s1 <= 2'h0;
      sync_s2 <= 2'h0;
      sync_s3 <= 2'h0;
      sync_q  <= 2'h0;
    end else begin
      sync_s1 <= {i_i2c_mode, i_load_select};
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sync_q  <= next_sync_q;
    end
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic        separate_r;
  logic        lsb_first_r;
  logic        bank_sel_r;
  logic [15:0] tag_buf;
  logic [15:0] tag_act;

  wire cfg_wr      = i_wr.en && (i_wr.addr == ADDR_PORT_CFG);
  wire bank_wr     = i_wr.en && (i_wr.addr == ADDR_BANK_SEL);
  wire tag_low_wr  = i_wr.en && (i_wr.addr == ADDR_TAG_LOW);
  wire tag_high_wr = i_wr.en && (i_wr.addr == ADDR_TAG_HIGH);
  // low nibble is only a mirror, so decoding uses the upper nibble alone
  wire soft_req    = cfg_wr && i_wr.data[CFG_SOFT_RST_BIT];
  // storage image when the load pin is high, on-chip defaults otherwise
  wire spcr_image_t reload = load_q ? i_nv_image : RST_IMAGE;
  // in I2C mode the wire-mode and order bits are not stored
  wire mode_wr     = cfg_wr && !i2c_q;

  wire        next_separate  = mode_wr ? i_wr.data[CFG_SEPARATE_BIT] : separate_r;
  wire        next_lsb_first = mode_wr ? i_wr.data[CFG_LSB_FIRST_BIT] : lsb_first_r;
  wire        next_bank_sel  = bank_wr ? i_wr.data[BANK_SEL_BIT] : bank_sel_r;
  wire [7:0]  next_tag_low   = tag_low_wr ? i_wr.data : tag_buf[7:0];
  wire [7:0]  next_tag_high  = tag_high_wr ? i_wr.data : tag_buf[15:8];
  // update copies the buffer as it stood before a same-cycle write
  wire [15:0] next_tag_act   = i_update ? tag_buf : tag_act;

  // ------------------------------------------------------------
  // register state; soft reset wins over any other write
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      separate_r  <= RST_SEPARATE;
      lsb_first_r <= RST_LSB_FIRST;
      bank_sel_r  <= RST_BANK_SEL;
      tag_buf     <= {RST_TAG_HIGH, RST_TAG_LOW};
      tag_act     <= {RST_TAG_HIGH, RST_TAG_LOW};
    end else if (soft_req) begin
      // bit 5 itself is never stored, so it clears itself
      separate_r  <= reload.separate_out;
      lsb_first_r <= reload.lsb_first;
      bank_sel_r  <= reload.bank_sel;
      tag_buf     <= reload.tag;
      tag_act     <= reload.tag;
    end else begin
      separate_r  <= next_separate;
      lsb_first_r <= next_lsb_first;
      bank_sel_r  <= next_bank_sel;
      tag_buf     <= {next_tag_high, next_tag_low};
      tag_act     <= next_tag_act;
    end
  end

  // ------------------------------------------------------------
  // read mux, one cycle latency
  // ------------------------------------------------------------
  // bits 7:6 read zero in I2C mode, bit 5 and bit 4 always zero
  wire [3:0] cfg_upper = {separate_r & ~i2c_q, lsb_first_r & ~i2c_q, 1'b0, 1'b0};
  wire [7:0] cfg_read  = {cfg_upper, cfg_upper[0], cfg_upper[1], cfg_upper[2], cfg_upper[3]};
  // bank select chooses buffered or active tag on readback
  wire [15:0] tag_view  = bank_sel_r ? tag_act : tag_buf;
  wire [7:0]  next_rd_data =
      (i_rd_addr == ADDR_PORT_CFG) ? cfg_read :
      (i_rd_addr == ADDR_VARIANT)  ? VARIANT_CODE :
      (i_rd_addr == ADDR_BANK_SEL) ? {7'h00, bank_sel_r} :
      (i_rd_addr == ADDR_TAG_LOW)  ? tag_view[7:0] :
      (i_rd_addr == ADDR_TAG_HIGH) ? tag_view[15:8] :
      READ_UNMAPPED;

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rd_data                <= READ_UNMAPPED;
      o_separate_output_enable <= RST_SEPARATE;
      o_lsb_first              <= RST_LSB_FIRST;
      o_soft_reset             <= 1'b0;
      o_nv_load                <= 1'b0;
      o_user_version_tag       <= {RST_TAG_HIGH, RST_TAG_LOW};
    end else begin
      o_rd_data                <= next_rd_data;
      o_separate_output_enable <= separate_r & ~i2c_q;
      o_lsb_first              <= lsb_first_r & ~i2c_q;
      o_soft_reset             <= soft_req;
      o_nv_load                <= soft_req & load_q;
      o_user_version_tag       <= tag_act;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_sep_out_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mode_wr && !soft_req && i_wr.data[CFG_SEPARATE_BIT]) ##1 !i2c_q
      |=> o_separate_output_enable)
    else $error("separate output not enabled after bit 7 write");

  a_order_msb: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mode_wr && !soft_req && !i_wr.data[CFG_LSB_FIRST_BIT]) ##1 !i2c_q |=> !o_lsb_first)
    else $error("lsb first set after clearing bit 6");

  a_i2c_ignores: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i2c_q |=> (!o_lsb_first && !o_separate_output_enable))
    else $error("mode bits active in i2c mode");

  a_soft_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    soft_req |=> o_soft_reset)
    else $error("soft reset pulse malformed");

  a_soft_source: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    soft_req |=> (tag_act == (($past(load_q)) ? $past(i_nv_image.tag) : RST_IMAGE.tag))
      && (o_nv_load == $past(load_q)))
    else $error("soft reset reloaded wrong image");

  a_variant_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd_addr == ADDR_VARIANT) |=> (o_rd_data == VARIANT_CODE))
    else $error("variant code read wrong");

  a_bank_view: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd_addr == ADDR_TAG_LOW)
      |=> (o_rd_data == ($past(bank_sel_r) ? $past(tag_act[7:0]) : $past(tag_buf[7:0]))))
    else $error("readback bank not honoured");

  a_cfg_mirror: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd_addr == ADDR_PORT_CFG) |=> (o_rd_data[CFG_SOFT_RST_BIT:CFG_UNUSED_BIT] == 2'h0)
      && (o_rd_data[3:0] == {o_rd_data[4], o_rd_data[5], o_rd_data[6], o_rd_data[7]}))
    else $error("config readback bits 5:4 or mirror wrong");

  a_tag_buffered: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (tag_low_wr && !i_update && !soft_req) |=> (tag_act == $past(tag_act))
      && (tag_buf[7:0] == $past(i_wr.data)))
    else $error("tag write reached active bank early");

  a_update_copy: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_update && !soft_req) |=> ##1 (o_user_version_tag == $past(tag_buf, 2)))
    else $error("update did not copy buffer to active");

  a_sep_out_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mode_wr && !soft_req && !i_wr.data[CFG_SEPARATE_BIT]) ##1 !i2c_q
      |=> !o_separate_output_enable)
    else $error("separate output still enabled after bit 7 clear");

  a_order_lsb: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (mode_wr && !soft_req && i_wr.data[CFG_LSB_FIRST_BIT]) ##1 !i2c_q |=> o_lsb_first)
    else $error("lsb first not set after setting bit 6");

  // output masking alone would hide a stored bit, so storage is checked too
  a_i2c_no_store: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (cfg_wr && i2c_q && !soft_req) |=> ($stable(separate_r) && $stable(lsb_first_r)))
    else $error("mode bits stored while in i2c mode");

  a_soft_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !soft_req |=> (!o_soft_reset && !o_nv_load))
    else $error("soft reset pulse longer than one cycle");

  a_bank_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (bank_wr && !soft_req) |=> (bank_sel_r == $past(i_wr.data[BANK_SEL_BIT])))
    else $error("bank select write not taken");

  a_bank_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd_addr == ADDR_BANK_SEL) |=> (o_rd_data == {7'h00, $past(bank_sel_r)}))
    else $error("bank select readback wrong");

  a_bank_view_high: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_rd_addr == ADDR_TAG_HIGH)
      |=> (o_rd_data == ($past(bank_sel_r) ? $past(tag_act[15:8]) : $past(tag_buf[15:8]))))
    else $error("readback bank not honoured on high byte");

endmodule

// file: testbench/spcr_host.sv
// host model: byte writes, byte reads and update pulses toward the bank
// assumes the bench owns clock, reset and the pin inputs
module spcr_host
  import spcr_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_rd_data,
  output spcr_wr_t        o_wr,
  output logic [11:0]     o_rd_addr,
  output logic            o_update
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr      = '0;
    o_rd_addr = 12'h000;
    o_update  = 1'b0;
  end
  // held across one rising edge, dropped at the next falling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_wr = '{en: 1'b1, addr: a, data: d};
    @(negedge i_core_clk);
    o_wr.en = 1'b0;
  endtask
  // low nibble reversed so either bit order decodes alike
  task automatic wr_cfg(input logic [3:0] hi);
    wr(ADDR_PORT_CFG, {hi, hi[0], hi[1], hi[2], hi[3]});
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_rd_addr = a;
    @(negedge i_core_clk);
    d = i_rd_data;
  endtask
  task automatic upd();
    @(negedge i_core_clk);
    o_update = 1'b1;
    @(negedge i_core_clk);
    o_update = 1'b0;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the serial port config register bank
// assumes the host model drives the byte access side
module testbench
  import spcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] VCODE = 8'h3C; // arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        i2c = 1'b0;
  logic        load_sel = 1'b0;
  spcr_image_t nv = '{1'b1, 1'b0, 1'b0, 16'hBEEF};
  spcr_wr_t    wr;
  logic [11:0] rda;
  logic        upd_p, sep, lsb, srst, nvl;
  logic [7:0]  rdd;
  logic [15:0] tag;
  int          errors = 0;
  int          compares = 0;
  always #20 clk = ~clk;
  spcr_regs #(.VARIANT_CODE(VCODE)) uut (.i_core_clk(clk), .i_sys_rst(rst), .i_wr(wr),
    .i_rd_addr(rda), .i_update(upd_p), .i_i2c_mode(i2c), .i_load_select(load_sel),
    .i_nv_image(nv), .o_rd_data(rdd), .o_separate_output_enable(sep), .o_lsb_first(lsb),
    .o_soft_reset(srst), .o_nv_load(nvl), .o_user_version_tag(tag));
  spcr_host host (.i_core_clk(clk), .i_rd_data(rdd), .o_wr(wr), .o_rd_addr(rda),
    .o_update(upd_p));
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input string n, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(4); // pin syncs settle
    chk("tag out", 16'h0000, tag);
    chk_rd("bank", ADDR_BANK_SEL, 8'h00);
    chk_rd("tag lo", ADDR_TAG_LOW, 8'h00);
    chk_rd("tag hi", ADDR_TAG_HIGH, 8'h00);
    chk_rd("variant", ADDR_VARIANT, VCODE);
    host.wr(ADDR_VARIANT, 8'hFF);
    chk_rd("variant ro", ADDR_VARIANT, VCODE);
    host.wr_cfg(4'hC);
    cyc(2);
    chk("sep", 16'h0001, 16'(sep));
    chk("lsb", 16'h0001, 16'(lsb));
    chk_rd("cfg", ADDR_PORT_CFG, 8'hC3);
    host.wr_cfg(4'h9); // bit 4 set too
    cyc(2);
    chk("lsb", 16'h0000, 16'(lsb));
    chk_rd("cfg", ADDR_PORT_CFG, 8'h81);
    host.wr_cfg(4'h0);
    cyc(2);
    chk("sep", 16'h0000, 16'(sep));
    i2c = 1'b1;
    cyc(6);
    host.wr_cfg(4'hC);
    cyc(2);
    chk("i2c sep", 16'h0000, 16'(sep));
    chk("i2c lsb", 16'h0000, 16'(lsb));
    chk_rd("i2c cfg", ADDR_PORT_CFG, 8'h00);
    i2c = 1'b0;
    cyc(6);
    // bits written in i2c mode must not surface once spi mode returns
    chk("kept sep", 16'h0000, 16'(sep));
    chk("kept lsb", 16'h0000, 16'(lsb));
    chk_rd("kept cfg", ADDR_PORT_CFG, 8'h00);
    host.wr(ADDR_TAG_LOW, 8'h12);
    host.wr(ADDR_TAG_HIGH, 8'h34);
    chk_rd("buf lo", ADDR_TAG_LOW, 8'h12);
    chk("tag out", 16'h0000, tag);
    host.wr(ADDR_BANK_SEL, 8'h01);
    chk_rd("bank", ADDR_BANK_SEL, 8'h01);
    chk_rd("act hi", ADDR_TAG_HIGH, 8'h00);
    host.upd();
    cyc(2);
    chk("tag out", 16'h3412, tag);
    chk_rd("act hi", ADDR_TAG_HIGH, 8'h34);
    // pulse stands only from the edge after the write to the next edge
    host.wr(ADDR_PORT_CFG, 8'h24);
    chk("srst", 16'h0001, 16'(srst));
    chk("nvl", 16'h0000, 16'(nvl));
    cyc(1);
    chk("srst", 16'h0000, 16'(srst));
    chk("tag out", 16'h0000, tag);
    chk_rd("bank", ADDR_BANK_SEL, 8'h00);
    load_sel = 1'b1;
    cyc(6);
    host.wr(ADDR_PORT_CFG, 8'h24);
    chk("nvl", 16'h0001, 16'(nvl));
    chk("srst", 16'h0001, 16'(srst));
    cyc(1);
    chk("tag out", 16'hBEEF, tag);
    chk("sep", 16'h0001, 16'(sep));
    summarize();
  end
  // about 100 cycles expected; far longer means a hang
  initial begin
    #(3000 * 40);
    errors++;
    summarize();
  end
endmodule
